// *** led_ind_pkg.sv ***
// Constants, field layout and mode decoding for the port LED indicator.
// Assumes a 50 MHz core clock and a 5-bit register address space.
package led_ind_pkg;

    // ==========================================================
    // Register map
    localparam logic [4:0] ADDR_INDICATOR_CONTROL = 5'h18;
    localparam logic [4:0] ADDR_PHY_CONTROL = 5'h19;
    localparam int ACT_RX_ONLY_BIT = 8;
    localparam int FLASH_LSB = 6;
    localparam int OVR_EN_LSB = 3;
    localparam int OVR_VAL_LSB = 0;
    localparam int MODE_LSB = 5;
    localparam logic [8:0] INDICATOR_CONTROL_RESET = 9'h000;
    localparam logic MODE_HIGH_RESET = 1'b0;

    // ==========================================================
    // LED positions
    localparam int POS_LINK = 0;
    localparam int POS_RATE = 1;
    localparam int POS_THIRD = 2;
    localparam int LED_COUNT = 3;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_DEFAULT_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int LINK_PULSE_MIN = 7;
    localparam int LINK_LOSS_MS = 50;
    localparam logic [6:0] FLASH_HALF_MS_0 = 7'h50;
    localparam logic [6:0] FLASH_HALF_MS_1 = 7'h28;
    localparam logic [6:0] FLASH_HALF_MS_2 = 7'h14;
    localparam logic [6:0] FLASH_HALF_MS_3 = 7'h0A;

    // ==========================================================
    // Modes
    typedef enum logic [1:0] {
        MODE_ACTIVITY,
        MODE_COLLISION,
        MODE_DUPLEX
    } indicator_mode_t;

    function automatic indicator_mode_t decode_mode(input logic [1:0] sel);
        if (sel[0]) begin
            return MODE_ACTIVITY;
        end else if (sel[1]) begin
            return MODE_DUPLEX;
        end
        return MODE_COLLISION;
    endfunction : decode_mode

    function automatic logic [6:0] flash_half_ms(input logic [1:0] sel);
        case (sel)
            2'h0: return FLASH_HALF_MS_0;
            2'h1: return FLASH_HALF_MS_1;
            2'h2: return FLASH_HALF_MS_2;
            default: return FLASH_HALF_MS_3;
        endcase
    endfunction : flash_half_ms

endpackage : led_ind_pkg

// *** pin_sync.sv ***
// Two-flop synchroniser for pin levels.
// Assumes the inputs are asynchronous to core_clk.
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input wire logic core_clk,
    // Levels
    input wire logic [WIDTH-1:0] pin_level,
    output logic [WIDTH-1:0] synced_level
);

    logic [WIDTH-1:0] meta;

    // No reset, so strap levels have settled before reset is released
    always_ff @(posedge core_clk) begin
        meta <= pin_level;
        synced_level <= meta;
    end

endmodule : pin_sync

// *** link_monitor.sv ***
// Link detection with link-pulse counting and a link-loss hold timer.
// Assumes a one-cycle millisecond tick from the same clock domain.
`timescale 1ns/1ns
module link_monitor import led_ind_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ms_tick,
    // Line status
    input wire logic speed_100,
    input wire logic signal_detect,
    input wire logic link_pulse,
    input wire logic good_packet,
    // Result
    output logic link_up
);

    logic [2:0] pulse_count;
    logic [5:0] quiet_ms;
    logic evidence;
    logic quiet_expired;
    logic pulses_done;

    assign evidence = speed_100 ? signal_detect : (link_pulse | good_packet);
    assign quiet_expired = (quiet_ms == 6'(LINK_LOSS_MS));
    assign pulses_done = link_pulse && (pulse_count == 3'(LINK_PULSE_MIN - 1));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse_count <= '0;
            quiet_ms <= '0;
            link_up <= 1'b0;
        end else begin
            if (evidence) begin
                quiet_ms <= '0;
            end else if (ms_tick && !quiet_expired) begin
                quiet_ms <= quiet_ms + 6'h01;
            end
            if (quiet_expired && !evidence) begin
                pulse_count <= '0;
                link_up <= 1'b0;
            end else if (speed_100) begin
                pulse_count <= '0;
                if (signal_detect) begin
                    link_up <= 1'b1;
                end
            end else begin
                if (link_pulse && pulse_count != 3'(LINK_PULSE_MIN)) begin
                    pulse_count <= pulse_count + 3'h1;
                end
                if (good_packet || pulses_done) begin
                    link_up <= 1'b1;
                end
            end
        end
    end

endmodule : link_monitor

// *** port_led_indicator.sv ***
// Per-port LED indicator: link, rate and shared activity/collision/duplex.
// Assumes line status inputs on core_clk; strap pins are asynchronous.
`timescale 1ns/1ns
module port_led_indicator import led_ind_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_DEFAULT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register access
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // Strap pins
    input wire logic carrier_sense_port_a_strap,
    input wire logic [2:0] negotiation_strap_input,
    // Line status
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic signal_detect,
    input wire logic link_pulse,
    input wire logic good_packet,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic mii_col,
    // LED pins
    output logic link_indicator,
    output logic rate_indicator,
    output logic activity_collision_indicator
);

    // ==========================================================
    // Strap capture
    logic [3:0] strap_sync;
    logic [LED_COUNT-1:0] active_low;

    pin_sync #(
        .WIDTH(4)
    ) u_strap_sync (
        .core_clk(core_clk),
        .pin_level({carrier_sense_port_a_strap, negotiation_strap_input}),
        .synced_level(strap_sync)
    );

    // ==========================================================
    // Registers
    logic [8:0] indicator_control;
    logic [1:0] indicator_mode_select;
    logic ctrl_hit;
    logic phy_hit;
    logic [15:0] next_rdata;
    logic activity_receive_only;
    logic [1:0] flash_rate_select;
    logic [LED_COUNT-1:0] ovr_en;
    logic [LED_COUNT-1:0] ovr_val;

    assign ctrl_hit = (reg_addr == ADDR_INDICATOR_CONTROL);
    assign phy_hit = (reg_addr == ADDR_PHY_CONTROL);
    assign activity_receive_only = indicator_control[ACT_RX_ONLY_BIT];
    assign flash_rate_select = indicator_control[FLASH_LSB +: 2];
    assign ovr_en = indicator_control[OVR_EN_LSB +: LED_COUNT];
    assign ovr_val = indicator_control[OVR_VAL_LSB +: LED_COUNT];

    always_comb begin
        next_rdata = 16'h0000;
        if (ctrl_hit) begin
            next_rdata = {7'h00, indicator_control};
        end else if (phy_hit) begin
            next_rdata[MODE_LSB +: 2] = indicator_mode_select;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_low <= strap_sync[2:0];
            indicator_control <= INDICATOR_CONTROL_RESET;
            indicator_mode_select <= {MODE_HIGH_RESET, strap_sync[3]};
            reg_rdata <= 16'h0000;
        end else begin
            if (reg_write && phy_hit) begin
                indicator_mode_select <= reg_wdata[MODE_LSB +: 2];
            end
            if (reg_write && ctrl_hit) begin
                indicator_control <= reg_wdata[8:0];
            end
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ==========================================================
    // Millisecond tick and blink
    logic [31:0] tick_count;
    logic ms_tick;
    logic [6:0] blink_ms;
    logic blink_phase;
    logic blink_turn;

    assign blink_turn = ms_tick
        && (blink_ms >= flash_half_ms(flash_rate_select) - 7'h01);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_count <= '0;
            ms_tick <= 1'b0;
            blink_ms <= '0;
            blink_phase <= 1'b0;
        end else begin
            ms_tick <= (tick_count == 32'(TICK_CYCLES - 1));
            if (tick_count == 32'(TICK_CYCLES - 1)) begin
                tick_count <= '0;
            end else begin
                tick_count <= tick_count + 32'h1;
            end
            if (blink_turn) begin
                blink_ms <= '0;
                blink_phase <= ~blink_phase;
            end else if (ms_tick) begin
                blink_ms <= blink_ms + 7'h01;
            end
        end
    end

    // ==========================================================
    // Link status
    logic link_up;

    link_monitor u_link (
        .core_clk(core_clk),
        .rst(rst),
        .ms_tick(ms_tick),
        .speed_100(speed_100),
        .signal_detect(signal_detect),
        .link_pulse(link_pulse),
        .good_packet(good_packet),
        .link_up(link_up)
    );

    // ==========================================================
    // Indication selection
    indicator_mode_t mode;
    logic activity;
    logic collision;
    logic link_on;
    logic third_on;
    logic [LED_COUNT-1:0] auto_on;
    logic [LED_COUNT-1:0] led_on;
    logic [LED_COUNT-1:0] next_pin;

    assign mode = decode_mode(indicator_mode_select);
    assign activity = activity_receive_only ? rx_active
                                            : (tx_active | rx_active);
    assign collision = mii_col & ~full_duplex;
    assign link_on = (mode == MODE_ACTIVITY) ? link_up
                   : (link_up & ~(activity & blink_phase));
    assign third_on = (mode == MODE_ACTIVITY) ? activity
                    : (mode == MODE_COLLISION) ? collision
                    : full_duplex;
    assign auto_on[POS_LINK] = link_on;
    assign auto_on[POS_RATE] = speed_100;
    assign auto_on[POS_THIRD] = third_on;

    generate
        for (genvar i = 0; i < LED_COUNT; i++) begin : g_led
            assign led_on[i] = ovr_en[i] ? ovr_val[i] : auto_on[i];
            assign next_pin[i] = led_on[i] ^ active_low[i];
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link_indicator <= 1'b0;
            rate_indicator <= 1'b0;
            activity_collision_indicator <= 1'b0;
        end else begin
            link_indicator <= next_pin[POS_LINK];
            rate_indicator <= next_pin[POS_RATE];
            activity_collision_indicator <= next_pin[POS_THIRD];
        end
    end

    // ==========================================================
    // Assertions
    property p_mode_write;
        @(posedge core_clk) disable iff (rst)
        reg_write && phy_hit
        |=> indicator_mode_select == $past(reg_wdata[6:5]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode field did not take the written value");

    property p_decode;
        @(posedge core_clk) disable iff (rst)
        indicator_mode_select[0] |-> mode == MODE_ACTIVITY;
    endproperty
    a_decode: assert property (p_decode)
        else $error("low mode bit set but mode is not activity");

    property p_link_dark;
        @(posedge core_clk) disable iff (rst)
        mode == MODE_ACTIVITY && !link_up && !ovr_en[POS_LINK]
        |=> link_indicator == active_low[POS_LINK];
    endproperty
    a_link_dark: assert property (p_link_dark)
        else $error("link LED lit without link");

    property p_blink;
        @(posedge core_clk) disable iff (rst)
        mode != MODE_ACTIVITY && link_up && !activity
            && !ovr_en[POS_LINK]
        |=> link_indicator == ~active_low[POS_LINK];
    endproperty
    a_blink: assert property (p_blink)
        else $error("link LED not steady with idle good link");

    property p_rate;
        @(posedge core_clk) disable iff (rst)
        !ovr_en[POS_RATE]
        |=> rate_indicator == ($past(speed_100) ^ active_low[POS_RATE]);
    endproperty
    a_rate: assert property (p_rate)
        else $error("rate LED does not follow speed");

    property p_act;
        @(posedge core_clk) disable iff (rst)
        mode == MODE_ACTIVITY && !ovr_en[POS_THIRD] && !activity_receive_only
        |=> activity_collision_indicator
            == ($past(tx_active | rx_active) ^ active_low[POS_THIRD]);
    endproperty
    a_act: assert property (p_act)
        else $error("third LED does not show activity");

    property p_col;
        @(posedge core_clk) disable iff (rst)
        mode == MODE_COLLISION && !ovr_en[POS_THIRD] && !full_duplex
        |=> activity_collision_indicator
            == ($past(mii_col) ^ active_low[POS_THIRD]);
    endproperty
    a_col: assert property (p_col)
        else $error("third LED does not show collision");

    property p_fdx_nocol;
        @(posedge core_clk) disable iff (rst)
        mode == MODE_COLLISION && !ovr_en[POS_THIRD] && full_duplex
        |=> activity_collision_indicator == active_low[POS_THIRD];
    endproperty
    a_fdx_nocol: assert property (p_fdx_nocol)
        else $error("collision shown in full duplex");

    property p_duplex;
        @(posedge core_clk) disable iff (rst)
        mode == MODE_DUPLEX && !ovr_en[POS_THIRD]
        |=> activity_collision_indicator
            == ($past(full_duplex) ^ active_low[POS_THIRD]);
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("third LED does not show duplex");

    property p_pol_stable;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> $stable(active_low);
    endproperty
    a_pol_stable: assert property (p_pol_stable)
        else $error("LED polarity changed after strap capture");

    property p_override;
        @(posedge core_clk) disable iff (rst)
        ovr_en[POS_LINK]
        |=> link_indicator
            == ($past(ovr_val[POS_LINK]) ^ active_low[POS_LINK]);
    endproperty
    a_override: assert property (p_override)
        else $error("link LED ignores direct control");

    property p_ctrl_read;
        @(posedge core_clk) disable iff (rst)
        reg_read && ctrl_hit
        |=> reg_rdata == {7'h00, $past(indicator_control)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read did not return stored bits");

    property p_link_hold;
        @(posedge core_clk) disable iff (rst)
        $fell(link_up) |-> $past(u_link.quiet_expired);
    endproperty
    a_link_hold: assert property (p_link_hold)
        else $error("link dropped before loss timer expired");

    property p_rx_only;
        @(posedge core_clk) disable iff (rst)
        mode == MODE_ACTIVITY && !ovr_en[POS_THIRD] && activity_receive_only
        |=> activity_collision_indicator
            == ($past(rx_active) ^ active_low[POS_THIRD]);
    endproperty
    a_rx_only: assert property (p_rx_only)
        else $error("third LED ignores receive-only activity source");

    property p_link_detect;
        @(posedge core_clk) disable iff (rst)
        speed_100 && signal_detect |=> link_up;
    endproperty
    a_link_detect: assert property (p_link_detect)
        else $error("link not raised on signal detect at 100 Mb/s");

    property p_strap_pol;
        @(posedge core_clk)
        $fell(rst) |-> active_low == strap_sync[2:0];
    endproperty
    a_strap_pol: assert property (p_strap_pol)
        else $error("LED polarity not taken from straps at reset");

    property p_strap_mode;
        @(posedge core_clk)
        $fell(rst)
        |-> indicator_mode_select == {MODE_HIGH_RESET, strap_sync[3]};
    endproperty
    a_strap_mode: assert property (p_strap_mode)
        else $error("mode field not loaded from strap at reset");

    c_collision: cover property (@(posedge core_clk) disable iff (rst)
        mode == MODE_COLLISION && collision);
    c_link_up: cover property (@(posedge core_clk) disable iff (rst)
        $rose(link_up));
    c_blink: cover property (@(posedge core_clk) disable iff (rst)
        mode == MODE_DUPLEX && link_up && activity && blink_turn);
    c_rx_only: cover property (@(posedge core_clk) disable iff (rst)
        mode == MODE_ACTIVITY && activity_receive_only && tx_active);

endmodule : port_led_indicator

// *** led_strap_model.sv ***
// Model of the board around one port: LED lamps and strap resistors.
// Assumes strap resistors stay fitted, so strap levels never change.
`timescale 1ns/1ns
module led_strap_model #(
    parameter logic [2:0] NEG_PULL = 3'h5,
    parameter logic CRS_PULL = 1'b1
) (
    // LED pins from the port
    input wire logic [2:0] led_pin,
    // Strap levels seen by the port
    output logic [2:0] neg_level,
    output logic crs_level,
    // Lamp states, 1 = glowing
    output logic [2:0] lit
);
    // ==========================================================
    // Straps and lamps
    assign neg_level = NEG_PULL;
    assign crs_level = CRS_PULL;
    // A pulled-up pin sinks lamp current, so its lamp glows on low
    assign lit = led_pin ^ NEG_PULL;
endmodule : led_strap_model

// *** tb_port_led_indicator.sv ***
// Self-checking bench for the port LED indicator with its board model.
// Assumes a short tick divider so link loss and blink fit a short run.
`timescale 1ns/1ns
module tb_port_led_indicator;
    import led_ind_pkg::*;
    localparam int TICKS = 10;
    typedef struct packed {
        logic kind;
        logic [15:0] mask;
        logic [15:0] val;
    } note_t;
    localparam logic [1:0] MODES [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
    logic core_clk, rst, reg_write, reg_read, crs_strap;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, seen;
    logic [2:0] neg_strap, led_pin, lit;
    logic speed_100, full_duplex, signal_detect, link_pulse, good_packet;
    logic tx_active, rx_active, mii_col, act, third, rxo, prev;
    logic [31:0] rnd;
    int err_total, cmp_count, cycles, tgl;
    note_t notes[$];
    note_t n;

    // ==========================================================
    // Design and board
    port_led_indicator #(.TICK_CYCLES(TICKS)) uut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .carrier_sense_port_a_strap(crs_strap),
        .negotiation_strap_input(neg_strap), .speed_100(speed_100),
        .full_duplex(full_duplex), .signal_detect(signal_detect),
        .link_pulse(link_pulse), .good_packet(good_packet),
        .tx_active(tx_active), .rx_active(rx_active), .mii_col(mii_col),
        .link_indicator(led_pin[0]), .rate_indicator(led_pin[1]),
        .activity_collision_indicator(led_pin[2]));
    led_strap_model board (.led_pin(led_pin), .neg_level(neg_strap),
        .crs_level(crs_strap), .lit(lit));

    // ==========================================================
    // Clock, timeout and result monitor
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    always @(posedge core_clk) begin
        if (!rst && notes.size() > 0) begin
            n = notes.pop_front();
            seen = n.kind ? reg_rdata : {13'h0, lit};
            check(seen & n.mask, n.val & n.mask);
        end
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask : tick
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        tick(1);
        reg_write = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr = a;
        reg_read = 1'b1;
        tick(1);
        reg_read = 1'b0;
        notes.push_back('{1'b1, 16'hFFFF, e});
        tick(1);
    endtask : rd
    task automatic lamps(input logic [2:0] m, input logic [2:0] v);
        tick(4);
        notes.push_back('{1'b0, {13'h0, m}, {13'h0, v}});
        tick(1);
    endtask : lamps
    task automatic pulse10(input int k);
        repeat (k) begin
            link_pulse = 1'b1;
            tick(1);
            link_pulse = 1'b0;
            tick(4);
        end
    endtask : pulse10
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Main sequence
    initial begin
        {rst, reg_write, reg_read, link_pulse, good_packet} = 5'h10;
        {speed_100, full_duplex, signal_detect} = 3'h5;
        {tx_active, rx_active, mii_col} = 3'h0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        rnd = $urandom(32'hd42a083d);
        tick(16);
        rst = 1'b0;
        tick(2);
        rd(ADDR_PHY_CONTROL, 16'h0020);
        rd(ADDR_INDICATOR_CONTROL, 16'h0000);
        lamps(3'h7, 3'h3);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_PHY_CONTROL, {9'h0, MODES[m], 5'h0});
            for (int k = 0; k < 12; k++) begin
                rnd = $urandom();
                {mii_col, rx_active, tx_active, full_duplex} = rnd[3:0];
                speed_100 = rnd[4];
                rxo = rnd[5];
                wr(ADDR_INDICATOR_CONTROL, {7'h0, rxo, 8'h0});
                act = rx_active | (tx_active & ~rxo);
                third = MODES[m][1] ? full_duplex : mii_col & ~full_duplex;
                third = MODES[m][0] ? act : third;
                lamps(3'h6, {third, speed_100, 1'b0});
            end
        end
        wr(ADDR_PHY_CONTROL, 16'hFFFF);
        rd(ADDR_PHY_CONTROL, 16'h0060);
        {speed_100, signal_detect, tx_active, rx_active} = 4'hC;
        lamps(3'h1, 3'h1);
        signal_detect = 1'b0;
        tick(100);
        lamps(3'h1, 3'h1);
        tick(600);
        lamps(3'h1, 3'h0);
        speed_100 = 1'b0;
        pulse10(6);
        lamps(3'h1, 3'h0);
        pulse10(1);
        lamps(3'h1, 3'h1);
        tick(600);
        lamps(3'h1, 3'h0);
        good_packet = 1'b1;
        tick(1);
        good_packet = 1'b0;
        lamps(3'h1, 3'h1);
        {speed_100, signal_detect, full_duplex, mii_col} = 4'hC;
        wr(ADDR_PHY_CONTROL, 16'h0000);
        wr(ADDR_INDICATOR_CONTROL, 16'h00C0);
        rx_active = 1'b1;
        tick(4);
        prev = lit[0];
        tgl = 0;
        repeat (400) begin
            tick(1);
            tgl += (lit[0] !== prev) ? 1 : 0;
            prev = lit[0];
        end
        check({15'h0, tgl >= 3 && tgl <= 4}, 16'h0001);
        rx_active = 1'b0;
        lamps(3'h1, 3'h1);
        wr(ADDR_INDICATOR_CONTROL, 16'hFFFF);
        lamps(3'h7, 3'h7);
        rd(ADDR_INDICATOR_CONTROL, 16'h01FF);
        wr(ADDR_INDICATOR_CONTROL, 16'h003A);
        lamps(3'h7, 3'h2);
        rd(ADDR_INDICATOR_CONTROL, 16'h003A);
        wr(5'h05, 16'h0000);
        rd(ADDR_INDICATOR_CONTROL, 16'h003A);
        rd(5'h05, 16'h0000);
        wr(ADDR_INDICATOR_CONTROL, 16'h0008);
        lamps(3'h7, 3'h2);
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(1);
        rd(ADDR_PHY_CONTROL, 16'h0020);
        lamps(3'h7, 3'h3);
        tick(4);
        print_verdict();
    end
endmodule : tb_port_led_indicator
